// ==== verilog/cpc_pkg.sv ====
package cpc_pkg;

   // ----------------------------------------------------------------
   // Bus and address widths
   // ----------------------------------------------------------------
   localparam int ADDR_W      = 32;
   localparam int DATA_W      = 32;
   localparam int PROG_ADDR_W = 21;

   // ----------------------------------------------------------------
   // Register indexes (byte address is four times the index)
   // ----------------------------------------------------------------
   localparam logic [23:0] IDX_BLOCK_LOCK = 24'h300008;
   localparam logic [23:0] IDX_BOOT_LOCK  = 24'h300009;
   localparam logic [23:0] IDX_ERASE_CTRL = 24'h300010;
   localparam logic [23:0] IDX_STATUS     = 24'h300011;

   function automatic logic [ADDR_W-1:0] idx_to_byte(logic [23:0] idx);
      return {6'h00, idx, 2'b00};
   endfunction

   localparam logic [ADDR_W-1:0] ADDR_BLOCK_LOCK = idx_to_byte(IDX_BLOCK_LOCK);
   localparam logic [ADDR_W-1:0] ADDR_BOOT_LOCK  = idx_to_byte(IDX_BOOT_LOCK);
   localparam logic [ADDR_W-1:0] ADDR_ERASE_CTRL = idx_to_byte(IDX_ERASE_CTRL);
   localparam logic [ADDR_W-1:0] ADDR_STATUS     = idx_to_byte(IDX_STATUS);

   // ----------------------------------------------------------------
   // Field positions and unprogrammed values
   // ----------------------------------------------------------------
   localparam int BIT_BLK_LSB  = 0;
   localparam int BIT_BLK3     = 3;
   localparam int BIT_BOOT     = 6;
   localparam int BIT_EEPROM   = 7;
   localparam int BIT_ERASE    = 0;
   localparam int BIT_VIOL     = 0;
   localparam int BIT_CNT_LSB  = 16;

   localparam logic [3:0]  BLK_UNPROG   = 4'hF;
   localparam logic        LOCK_UNPROG  = 1'b1;
   localparam logic [15:0] CNT_RESET    = 16'h0000;
   localparam logic [15:0] CNT_MAX      = 16'hFFFF;

   // ----------------------------------------------------------------
   // Program memory regions
   // ----------------------------------------------------------------
   localparam logic [PROG_ADDR_W-1:0] BOOT_LAST  = 21'h0007FF;
   localparam logic [PROG_ADDR_W-1:0] BLK0_FIRST = 21'h000800;
   localparam logic [PROG_ADDR_W-1:0] BLK3_LAST  = 21'h007FFF;
   localparam int                     BLK_SHIFT  = 13;

   // ----------------------------------------------------------------
   // Bus responses
   // ----------------------------------------------------------------
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   // Active high: 1 means the region is read-protected
   typedef struct packed {
      logic       eeprom;
      logic       boot;
      logic [3:0] blk;
   } cpc_lock_t;

   typedef struct packed {
      logic                   valid;
      logic                   eeprom;
      logic [PROG_ADDR_W-1:0] addr;
   } cpc_chk_req_t;

   typedef struct packed {
      logic done;
      logic deny;
   } cpc_chk_rsp_t;

endpackage

// ==== verilog/cpc_region_check.sv ====
`timescale 1ns/1ns
module cpc_region_check (
   input  cpc_pkg::cpc_chk_req_t req,
   input  cpc_pkg::cpc_lock_t    lock,
   output logic                  deny
);
   import cpc_pkg::*;

   function automatic logic prog_locked(logic [PROG_ADDR_W-1:0] a,
                                        cpc_lock_t             l);
      logic [1:0] blk;
      blk = a[BLK_SHIFT+1:BLK_SHIFT];
      if (a <= BOOT_LAST) begin
         return l.boot;
      end
      if (a >= BLK0_FIRST && a <= BLK3_LAST) begin
         return l.blk[blk];
      end
      // Above the last block nothing is guarded
      return 1'b0;
   endfunction

   always_comb begin
      if (req.eeprom) begin
         deny = lock.eeprom;
      end else begin
         deny = prog_locked(req.addr, lock);
      end
   end

endmodule

// ==== verilog/cpc_axil_slave.sv ====
`timescale 1ns/1ns
module cpc_axil_slave (
   input  wire logic                        clk,
   input  wire logic                        rst,
   input  wire logic [cpc_pkg::ADDR_W-1:0]  awaddr,
   input  wire logic                        awvalid,
   output logic                             awready,
   input  wire logic [cpc_pkg::DATA_W-1:0]  wdata,
   input  wire logic [3:0]                  wstrb,
   input  wire logic                        wvalid,
   output logic                             wready,
   output logic [1:0]                       bresp,
   output logic                             bvalid,
   input  wire logic                        bready,
   input  wire logic [cpc_pkg::ADDR_W-1:0]  araddr,
   input  wire logic                        arvalid,
   output logic                             arready,
   output logic [cpc_pkg::DATA_W-1:0]       rdata,
   output logic [1:0]                       rresp,
   output logic                             rvalid,
   input  wire logic                        rready,
   output logic                             wr_en,
   output logic [cpc_pkg::ADDR_W-1:0]       wr_addr,
   output logic [cpc_pkg::DATA_W-1:0]       wr_data,
   output logic [3:0]                       wr_strb,
   input  wire logic                        wr_ok,
   output logic                             rd_en,
   output logic [cpc_pkg::ADDR_W-1:0]       rd_addr,
   input  wire logic [cpc_pkg::DATA_W-1:0]  rd_data,
   input  wire logic                        rd_ok
);
   import cpc_pkg::*;

   logic awready_r;
   logic wready_r;
   logic bvalid_r;
   logic arready_r;
   logic rvalid_r;
   logic rd_pend_r;
   logic [1:0] bresp_r;
   logic [1:0] rresp_r;
   logic [DATA_W-1:0] rdata_r;
   logic [ADDR_W-1:0] aw_addr_r;
   logic [ADDR_W-1:0] ar_addr_r;
   logic [DATA_W-1:0] w_data_r;
   logic [3:0]        w_strb_r;

   // ----------------------------------------------------------------
   // Write channels
   // ----------------------------------------------------------------
   // Address and data may arrive in either order
   always_ff @(posedge clk) begin
      if (rst) begin
         awready_r <= 1'b1;
         aw_addr_r <= '0;
      end else if (awvalid && awready_r) begin
         awready_r <= 1'b0;
         aw_addr_r <= awaddr;
      end else if (bvalid_r && bready) begin
         awready_r <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wready_r <= 1'b1;
         w_data_r <= '0;
         w_strb_r <= 4'h0;
      end else if (wvalid && wready_r) begin
         wready_r <= 1'b0;
         w_data_r <= wdata;
         w_strb_r <= wstrb;
      end else if (bvalid_r && bready) begin
         wready_r <= 1'b1;
      end
   end

   assign wr_en   = !awready_r && !wready_r && !bvalid_r;
   assign wr_addr = aw_addr_r;
   assign wr_data = w_data_r;
   assign wr_strb = w_strb_r;

   always_ff @(posedge clk) begin
      if (rst) begin
         bvalid_r <= 1'b0;
         bresp_r  <= RESP_OKAY;
      end else if (wr_en) begin
         bvalid_r <= 1'b1;
         bresp_r  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_r && bready) begin
         bvalid_r <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Read channels
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         arready_r <= 1'b1;
         ar_addr_r <= '0;
         rd_pend_r <= 1'b0;
      end else if (arvalid && arready_r) begin
         arready_r <= 1'b0;
         ar_addr_r <= araddr;
         rd_pend_r <= 1'b1;
      end else if (rd_pend_r) begin
         rd_pend_r <= 1'b0;
      end else if (rvalid_r && rready) begin
         arready_r <= 1'b1;
      end
   end

   assign rd_en   = rd_pend_r;
   assign rd_addr = ar_addr_r;

   always_ff @(posedge clk) begin
      if (rst) begin
         rvalid_r <= 1'b0;
         rdata_r  <= '0;
         rresp_r  <= RESP_OKAY;
      end else if (rd_pend_r) begin
         rvalid_r <= 1'b1;
         rdata_r  <= rd_ok ? rd_data : '0;
         rresp_r  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_r && rready) begin
         rvalid_r <= 1'b0;
      end
   end

   assign awready = awready_r;
   assign wready  = wready_r;
   assign bvalid  = bvalid_r;
   assign bresp   = bresp_r;
   assign arready = arready_r;
   assign rvalid  = rvalid_r;
   assign rdata   = rdata_r;
   assign rresp   = rresp_r;

endmodule

// ==== verilog/cpc_code_protect.sv ====
// Overview of operation
// - Block lock bits 3..0 of low byte are active low; 0 guards the block.
// - Boot bit 6 of high byte at 0 guards 000000-0007FF.
// - EEPROM bit 7 of high byte at 0 guards the data EEPROM.
// - Unimplemented bits of both bytes read as zero; an absent block 3 bit reads as one.
// - Low byte sits at index 300008, high byte at index 300009.
`timescale 1ns/1ns
module cpc_code_protect #(
   parameter bit BLOCK3_PRESENT = 1'b1
) (
   input  wire logic                        clk,
   input  wire logic                        rst,
   input  wire logic [cpc_pkg::ADDR_W-1:0]  awaddr,
   input  wire logic                        awvalid,
   output logic                             awready,
   input  wire logic [cpc_pkg::DATA_W-1:0]  wdata,
   input  wire logic [3:0]                  wstrb,
   input  wire logic                        wvalid,
   output logic                             wready,
   output logic [1:0]                       bresp,
   output logic                             bvalid,
   input  wire logic                        bready,
   input  wire logic [cpc_pkg::ADDR_W-1:0]  araddr,
   input  wire logic                        arvalid,
   output logic                             arready,
   output logic [cpc_pkg::DATA_W-1:0]       rdata,
   output logic [1:0]                       rresp,
   output logic                             rvalid,
   input  wire logic                        rready,
   input  wire cpc_pkg::cpc_chk_req_t       chk_req,
   output cpc_pkg::cpc_chk_rsp_t            chk_rsp,
   output cpc_pkg::cpc_lock_t               lock_state
);
   import cpc_pkg::*;

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic              wr_en;
   logic [ADDR_W-1:0] wr_addr;
   logic [DATA_W-1:0] wr_data;
   logic [3:0]        wr_strb;
   logic              wr_ok;
   logic              rd_en;
   logic [ADDR_W-1:0] rd_addr;
   logic [DATA_W-1:0] rd_data;
   logic              rd_ok;

   logic [3:0]        block_lock_n_r;
   logic              boot_region_lock_n_r;
   logic              eeprom_read_lock_n_r;
   logic              viol_r;
   logic [15:0]       deny_cnt_r;
   cpc_chk_rsp_t      chk_rsp_r;
   cpc_lock_t         lock_r;

   logic              hit_low;
   logic              hit_high;
   logic              hit_erase;
   logic              hit_status;
   logic              wr_low;
   logic              wr_high;
   logic              erase_go;
   logic              viol_clr;
   logic [3:0]        blk_keep;
   logic [3:0]        blk_nxt;
   cpc_lock_t         lock_now;
   logic              deny_c;
   logic              deny_ev;

   // Per-bit views of the lock bytes
   logic block0_read_lock_n;
   logic block1_read_lock_n;
   logic block2_read_lock_n;
   logic block3_read_lock_n;
   logic boot_region_lock_n;
   logic eeprom_read_lock_n;

   function automatic logic addr_is(logic [ADDR_W-1:0] a,
                                    logic [ADDR_W-1:0] b);
      return a == b;
   endfunction

   // ----------------------------------------------------------------
   // Bus slave
   // ----------------------------------------------------------------
   cpc_axil_slave u_bus (
      .clk     (clk),
      .rst     (rst),
      .awaddr  (awaddr),
      .awvalid (awvalid),
      .awready (awready),
      .wdata   (wdata),
      .wstrb   (wstrb),
      .wvalid  (wvalid),
      .wready  (wready),
      .bresp   (bresp),
      .bvalid  (bvalid),
      .bready  (bready),
      .araddr  (araddr),
      .arvalid (arvalid),
      .arready (arready),
      .rdata   (rdata),
      .rresp   (rresp),
      .rvalid  (rvalid),
      .rready  (rready),
      .wr_en   (wr_en),
      .wr_addr (wr_addr),
      .wr_data (wr_data),
      .wr_strb (wr_strb),
      .wr_ok   (wr_ok),
      .rd_en   (rd_en),
      .rd_addr (rd_addr),
      .rd_data (rd_data),
      .rd_ok   (rd_ok)
   );

   // ----------------------------------------------------------------
   // Write decode
   // ----------------------------------------------------------------
   // byte placement
   assign hit_low    = addr_is(wr_addr, ADDR_BLOCK_LOCK);
   assign hit_high   = addr_is(wr_addr, ADDR_BOOT_LOCK);
   assign hit_erase  = addr_is(wr_addr, ADDR_ERASE_CTRL);
   assign hit_status = addr_is(wr_addr, ADDR_STATUS);
   assign wr_ok      = hit_low || hit_high || hit_erase || hit_status;

   assign wr_low   = wr_en && hit_low && wr_strb[0];
   assign wr_high  = wr_en && hit_high && wr_strb[0];
   assign erase_go = wr_en && hit_erase && wr_strb[0]
                     && wr_data[BIT_ERASE];
   assign viol_clr = wr_en && hit_status && wr_strb[0]
                     && wr_data[BIT_VIOL];

   // absent block 3 bit held set whatever is written
   assign blk_keep = BLOCK3_PRESENT ? 4'h0 : 4'h8;
   assign blk_nxt  = block_lock_n_r
                     & (wr_data[BIT_BLK_LSB+3:BIT_BLK_LSB] | blk_keep);

   // ----------------------------------------------------------------
   // Lock bits
   // ----------------------------------------------------------------
   // No nonvolatile store here: reset loads the unprogrammed state,
   // so the surrounding system must reload programmed bytes.
   // erase restores, write only clears
   always_ff @(posedge clk) begin
      if (rst) begin
         block_lock_n_r <= BLK_UNPROG;
      end else if (erase_go) begin
         block_lock_n_r <= BLK_UNPROG;
      end else if (wr_low) begin
         block_lock_n_r <= blk_nxt;
      end
   end

   // boot and eeprom bits, erase restores, write only clears
   always_ff @(posedge clk) begin
      if (rst) begin
         boot_region_lock_n_r <= LOCK_UNPROG;
         eeprom_read_lock_n_r <= LOCK_UNPROG;
      end else if (erase_go) begin
         boot_region_lock_n_r <= LOCK_UNPROG;
         eeprom_read_lock_n_r <= LOCK_UNPROG;
      end else if (wr_high) begin
         boot_region_lock_n_r <= boot_region_lock_n_r
                                 & wr_data[BIT_BOOT];
         eeprom_read_lock_n_r <= eeprom_read_lock_n_r
                                 & wr_data[BIT_EEPROM];
      end
   end

   assign block0_read_lock_n = block_lock_n_r[0];
   assign block1_read_lock_n = block_lock_n_r[1];
   assign block2_read_lock_n = block_lock_n_r[2];
   assign block3_read_lock_n = block_lock_n_r[BIT_BLK3];
   assign boot_region_lock_n = boot_region_lock_n_r;
   assign eeprom_read_lock_n = eeprom_read_lock_n_r;

   // ----------------------------------------------------------------
   // Protection view, active high
   // ----------------------------------------------------------------
   // a cleared bit guards its block
   always_comb begin
      lock_now.blk[0] = !block0_read_lock_n;
      lock_now.blk[1] = !block1_read_lock_n;
      lock_now.blk[2] = !block2_read_lock_n;
      lock_now.blk[3] = BLOCK3_PRESENT && !block3_read_lock_n;
      lock_now.boot   = !boot_region_lock_n;
      lock_now.eeprom = !eeprom_read_lock_n;
   end

   cpc_region_check u_check (
      .req  (chk_req),
      .lock (lock_now),
      .deny (deny_c)
   );

   assign deny_ev = chk_req.valid && deny_c;

   // verdict one cycle after the request
   always_ff @(posedge clk) begin
      if (rst) begin
         chk_rsp_r <= '0;
      end else begin
         chk_rsp_r.done <= chk_req.valid;
         chk_rsp_r.deny <= deny_ev;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         lock_r <= '0;
      end else begin
         lock_r <= lock_now;
      end
   end

   // ----------------------------------------------------------------
   // Denial record
   // ----------------------------------------------------------------
   // A denial in the clearing cycle is kept: set wins
   always_ff @(posedge clk) begin
      if (rst) begin
         viol_r <= 1'b0;
      end else if (deny_ev) begin
         viol_r <= 1'b1;
      end else if (viol_clr) begin
         viol_r <= 1'b0;
      end
   end

   // Saturates rather than wraps so a flood never reads as quiet
   always_ff @(posedge clk) begin
      if (rst) begin
         deny_cnt_r <= CNT_RESET;
      end else if (erase_go) begin
         deny_cnt_r <= CNT_RESET;
      end else if (deny_ev && deny_cnt_r != CNT_MAX) begin
         deny_cnt_r <= deny_cnt_r + 16'h0001;
      end
   end

   // ----------------------------------------------------------------
   // Read decode
   // ----------------------------------------------------------------
   // unimplemented bits read as zero, an absent block 3 bit as one
   always_comb begin
      rd_data = '0;
      rd_ok   = 1'b1;
      if (addr_is(rd_addr, ADDR_BLOCK_LOCK)) begin
         rd_data[BIT_BLK_LSB+3:BIT_BLK_LSB] = block_lock_n_r;
      end else if (addr_is(rd_addr, ADDR_BOOT_LOCK)) begin
         rd_data[BIT_BOOT]   = boot_region_lock_n_r;
         rd_data[BIT_EEPROM] = eeprom_read_lock_n_r;
      end else if (addr_is(rd_addr, ADDR_ERASE_CTRL)) begin
         rd_data = '0;
      end else if (addr_is(rd_addr, ADDR_STATUS)) begin
         rd_data[BIT_VIOL] = viol_r;
         rd_data[BIT_CNT_LSB+15:BIT_CNT_LSB] = deny_cnt_r;
      end else begin
         rd_ok = 1'b0;
      end
      // Idle bus shows zero; the rdata output still holds the last word read
      if (!rd_en) begin
         rd_data = '0;
      end
   end

   assign chk_rsp    = chk_rsp_r;
   assign lock_state = lock_r;

endmodule

// ==== tb/cpc_chk.sv ====
`timescale 1ns/1ns
module cpc_chk (
   input wire logic                       clk,
   input wire logic                       rst,
   input wire logic [cpc_pkg::ADDR_W-1:0] araddr,
   input wire logic                       arvalid,
   input wire logic                       arready,
   input wire logic [cpc_pkg::DATA_W-1:0] rdata,
   input wire logic                       rvalid,
   input wire logic                       bvalid,
   input wire cpc_pkg::cpc_chk_req_t      chk_req,
   input wire cpc_pkg::cpc_chk_rsp_t      chk_rsp,
   input wire cpc_pkg::cpc_lock_t         lock_state
);
   import cpc_pkg::*;
   logic [ADDR_W-1:0] ra_r;
   logic              prog_q;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // Address of the read in flight
   always_ff @(posedge clk) begin
      if (rst) begin
         ra_r <= '0;
      end else if (arvalid && arready) begin
         ra_r <= araddr;
      end
   end
   assign prog_q = chk_req.valid && !chk_req.eeprom;
   sequence ar_take;
      arvalid && arready;
   endsequence
   sequence r_late;
      !rvalid ##1 rvalid;
   endsequence
   rd_lat_a: assert property (ar_take |=> r_late)
      else $error("read answer timing wrong");
   chk_done_a: assert property (chk_req.valid |=> chk_rsp.done)
      else $error("check answer missing");
   blk_deny_a: assert property (prog_q && chk_req.addr >= BLK0_FIRST
      && chk_req.addr <= BLK3_LAST
      |=> chk_rsp.deny == lock_state.blk[$past(chk_req.addr[14:13])])
      else $error("block deny wrong");
   boot_deny_a: assert property (prog_q && chk_req.addr <= BOOT_LAST
      |=> chk_rsp.deny == lock_state.boot)
      else $error("boot deny wrong");
   eep_deny_a: assert property (chk_req.valid && chk_req.eeprom
      |=> chk_rsp.deny == lock_state.eeprom)
      else $error("eeprom deny wrong");
   high_open_a: assert property (prog_q && chk_req.addr > BLK3_LAST
      |=> !chk_rsp.deny)
      else $error("unguarded space denied");
   rsvd_zero_a: assert property (
      rvalid |-> (ra_r != ADDR_BLOCK_LOCK || rdata[31:4] == 0)
      && (ra_r != ADDR_BOOT_LOCK || {rdata[31:8], rdata[5:0]} == 0))
      else $error("unimplemented bits not zero");
   // Protection is only lifted in the two cycles after a write response
   lock_keep_a: assert property (
      ($past(lock_state) & ~lock_state) != 0
      |-> $past(bvalid) || $past(bvalid, 2))
      else $error("lock released without write");
endmodule
bind cpc_code_protect cpc_chk cpc_chk_inst (
   .clk(clk), .rst(rst), .araddr(araddr), .arvalid(arvalid),
   .arready(arready), .rdata(rdata), .rvalid(rvalid), .bvalid(bvalid),
   .chk_req(chk_req), .chk_rsp(chk_rsp), .lock_state(lock_state));

// ==== tb/cpc_prog_model.sv ====
`timescale 1ns/1ns
module cpc_prog_model #(
   parameter bit REDUCED = 1'b0
) (
   input  wire logic                       clk,
   output logic [cpc_pkg::ADDR_W-1:0]      awaddr,
   output logic                            awvalid,
   input  wire logic                       awready,
   output logic [cpc_pkg::DATA_W-1:0]      wdata,
   output logic [3:0]                      wstrb,
   output logic                            wvalid,
   input  wire logic                       wready,
   input  wire logic [1:0]                 bresp,
   input  wire logic                       bvalid,
   output logic                            bready,
   output logic [cpc_pkg::ADDR_W-1:0]      araddr,
   output logic                            arvalid,
   input  wire logic                       arready,
   input  wire logic [cpc_pkg::DATA_W-1:0] rdata,
   input  wire logic [1:0]                 rresp,
   input  wire logic                       rvalid,
   output logic                            rready
);
   import cpc_pkg::*;
   // Cycles before the answer is accepted, to act slow
   int lag = 0;
   initial begin
      {awaddr, wdata, araddr, wstrb} = '0;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
   end
   // Released address and data lines show the inverse; wstrb keeps its last value
   task automatic write(input logic [ADDR_W-1:0] a,
      input logic [DATA_W-1:0] d, output logic [1:0] r, output bit ok);
      ok = 1'b0;
      r = 2'h3;
      // small part keeps block 3 bit set
      if (REDUCED && a == ADDR_BLOCK_LOCK) d[BIT_BLK3] = 1'b1;
      @(posedge clk);
      {awaddr, wdata, wstrb} <= {a, d, 4'hF};
      {awvalid, wvalid} <= 2'b11;
      for (int n = 0; n < 200 && !ok; n++) begin
         @(posedge clk);
         if (awvalid && awready) begin
            {awvalid, awaddr} <= {1'b0, ~a};
         end
         if (wvalid && wready) begin
            {wvalid, wdata} <= {1'b0, ~d};
         end
         if (bready && bvalid) begin
            r = bresp;
            ok = 1'b1;
            bready <= 1'b0;
         end else if (n >= lag) begin
            bready <= 1'b1;
         end
      end
   endtask
   task automatic read(input logic [ADDR_W-1:0] a,
      output logic [DATA_W-1:0] d, output logic [1:0] r, output bit ok);
      ok = 1'b0;
      {d, r} = '1;
      @(posedge clk);
      {araddr, arvalid} <= {a, 1'b1};
      for (int n = 0; n < 200 && !ok; n++) begin
         @(posedge clk);
         if (arvalid && arready) begin
            {arvalid, araddr} <= {1'b0, ~a};
         end
         if (rready && rvalid) begin
            {d, r} = {rdata, rresp};
            ok = 1'b1;
            rready <= 1'b0;
         end else if (n >= lag) begin
            rready <= 1'b1;
         end
      end
   endtask
endmodule

// ==== tb/test_code_protect_config.sv ====
`timescale 1ns/1ns
module test_code_protect_config;
   import cpc_pkg::*;
   logic              clk, rst;
   logic [ADDR_W-1:0] awaddr, araddr;
   logic [DATA_W-1:0] wdata, rdata, rd_v;
   logic [3:0]        wstrb;
   logic              awvalid, awready, wvalid, wready, bvalid, bready;
   logic              arvalid, arready, rvalid, rready;
   logic [1:0]        bresp, rresp, rsp;
   cpc_chk_req_t      chk_req;
   cpc_chk_rsp_t      chk_rsp;
   cpc_lock_t         lock_state;
   int                n_mismatch = 0;
   int                check_count = 0;
   cpc_code_protect cpc_code_protect_inst (.clk(clk), .rst(rst),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready), .chk_req(chk_req),
      .chk_rsp(chk_rsp), .lock_state(lock_state));
   cpc_prog_model cpc_prog_model_inst (.clk(clk), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] s, e);
      check_count++;
      if (s !== e) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic wr(input logic [31:0] a, d, input logic [1:0] er);
      bit ok;
      cpc_prog_model_inst.write(a, d, rsp, ok);
      if (!ok) begin
         n_mismatch++;
         end_of_test();
      end
      chk("bresp", 32'(rsp), 32'(er));
   endtask
   task automatic rd(input logic [31:0] a, input logic [1:0] er);
      bit ok;
      cpc_prog_model_inst.read(a, rd_v, rsp, ok);
      if (!ok) begin
         n_mismatch++;
         end_of_test();
      end
      chk("rresp", 32'(rsp), 32'(er));
   endtask
   // Done and deny stand one cycle after the request edge
   task automatic probe(input logic [20:0] a, input logic e, x);
      @(posedge clk);
      chk_req <= {1'b1, e, a};
      @(posedge clk);
      chk_req.valid <= 1'b0;
      @(negedge clk);
      chk("done", 32'(chk_rsp.done), 32'h1);
      chk("deny", 32'(chk_rsp.deny), 32'(x));
   endtask
   task automatic t_reset();
      logic [31:0] ad [2] = '{ADDR_BLOCK_LOCK, ADDR_BOOT_LOCK};
      logic [31:0] ev [2] = '{32'h0000000F, 32'h000000C0};
      chk("lock_rst", 32'(lock_state), 32'h0);
      for (int i = 0; i < 2; i++) begin
         rd(ad[i], RESP_OKAY);
         chk("cfg_rst", rd_v, ev[i]);
         wr(ad[i], 32'hFFFFFFFF, RESP_OKAY);
         rd(ad[i], RESP_OKAY);
         chk("cfg_rsvd", rd_v, ev[i]);
      end
      $display("t_reset done");
   endtask
   task automatic t_blocks();
      logic [3:0] m = 4'hF;
      for (int i = 0; i < 4; i++) begin
         probe({i[1:0], 13'h1FFF}, 1'b0, 1'b0);
         m[i] = 1'b0;
         wr(ADDR_BLOCK_LOCK, {28'h0, 4'hF ^ (4'h1 << i)}, RESP_OKAY);
         probe(i == 0 ? BLK0_FIRST : {i[1:0], 13'h0}, 1'b0, 1'b1);
         probe({i[1:0], 13'h1FFF}, 1'b0, 1'b1);
         // Setting bits back must not lift protection
         wr(ADDR_BLOCK_LOCK, 32'h0000000F, RESP_OKAY);
         rd(ADDR_BLOCK_LOCK, RESP_OKAY);
         chk("blk_lock", rd_v, {28'h0, m});
      end
      probe(BOOT_LAST, 1'b0, 1'b0);
      probe(21'h008000, 1'b0, 1'b0);
      $display("t_blocks done");
   endtask
   task automatic t_boot();
      probe(21'h0, 1'b1, 1'b0);
      wr(ADDR_BOOT_LOCK, 32'h00000080, RESP_OKAY);
      probe(21'h0, 1'b0, 1'b1);
      probe(BOOT_LAST, 1'b0, 1'b1);
      probe(21'h0, 1'b1, 1'b0);
      wr(ADDR_BOOT_LOCK, 32'h00000040, RESP_OKAY);
      probe(BOOT_LAST, 1'b1, 1'b1);
      rd(ADDR_BOOT_LOCK, RESP_OKAY);
      chk("boot_lock", rd_v, 32'h0);
      $display("t_boot done");
   endtask
   task automatic t_erase();
      cpc_prog_model_inst.lag = 3;
      rd(ADDR_STATUS, RESP_OKAY);
      chk("stat", rd_v, 32'h000B0001);
      wr(ADDR_ERASE_CTRL, 32'h00000001, RESP_OKAY);
      wr(ADDR_STATUS, 32'h00000001, RESP_OKAY);
      rd(ADDR_STATUS, RESP_OKAY);
      chk("stat_clr", rd_v, 32'h0);
      rd(ADDR_BLOCK_LOCK, RESP_OKAY);
      chk("blk_erase", rd_v, 32'h0000000F);
      rd(ADDR_BOOT_LOCK, RESP_OKAY);
      chk("boot_erase", rd_v, 32'h000000C0);
      probe(21'h006000, 1'b0, 1'b0);
      wr(32'h00000100, 32'h00000000, RESP_SLVERR);
      rd(32'h00000100, RESP_SLVERR);
      chk("unmapped", rd_v, 32'h0);
      $display("t_erase done");
   endtask
   initial begin
      rst = 1'b1;
      chk_req = '0;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_blocks();
      t_boot();
      t_erase();
      end_of_test();
   end
endmodule
